//--- design/mst_defines.svh
// Constants for the microstep translator
`ifndef MST_DEFINES_SVH
`define MST_DEFINES_SVH

`define MST_CLK_PERIOD_NS  40
`define MST_IDX_W          6
`define MST_LVL_W          7
`define MST_HOME_IDX       6'h08
`define MST_INC_FULL       6'h10
`define MST_INC_HALF       6'h08
`define MST_INC_QUARTER    6'h04
`define MST_INC_SIXTEENTH  6'h01
`define MST_QUAD_SPAN      5'h10
`define MST_PHASE2_OFFSET  6'h10
`define MST_SYNC_W         8
`define MST_SYNC_RESET     8'h30
`define MST_FAST_PERMILLE  301
`define MST_PERMILLE       1000
`define MST_TOFF_NS        25000
`define MST_RP_MIN_NS      1000
`define MST_RP_MAX_NS      100000
`define MST_SETTLE_NS      1000000

`endif

//--- design/mst_off_timer.sv
// Fixed off-time sequencer for one bridge
`timescale 1ns/1ps
`default_nettype none
`include "mst_defines.svh"

module mst_off_timer
    import mst_pkg::*;
#(
    parameter int TOFF_NS = `MST_TOFF_NS,
    parameter int CNT_W   = 16
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic enable_i,
    input  wire logic mixed_i,
    input  wire logic trip_i,
    output var  logic drive_o,
    output var  logic fast_decay_o
);
    localparam int TOFF_CYC = (TOFF_NS / `MST_CLK_PERIOD_NS < 1) ? 1 : TOFF_NS / `MST_CLK_PERIOD_NS;
    localparam int FAST_CYC = (TOFF_CYC * `MST_FAST_PERMILLE) / `MST_PERMILLE;
    localparam logic [CNT_W-1:0] TOFF_LAST = CNT_W'(TOFF_CYC - 1);
    localparam logic [CNT_W-1:0] FAST_END  = CNT_W'(FAST_CYC);

    mst_chop_t         state_r;
    logic [CNT_W-1:0]  cnt_r;
    logic              fast_r;

    // ------------------------------------------------------------
    // Chopping sequence
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= MST_CHOP_DRIVE;
            cnt_r   <= '0;
            fast_r  <= 1'b0;
        end else begin
            case (state_r)
                MST_CHOP_DRIVE: begin
                    cnt_r <= '0;
                    if (enable_i && trip_i) begin
                        // Fast portion only in mixed decay
                        state_r <= (mixed_i && FAST_CYC > 0) ? MST_CHOP_FAST : MST_CHOP_SLOW;
                        fast_r  <= mixed_i && FAST_CYC > 0;
                    end
                end
                MST_CHOP_FAST: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r + 1'b1 >= FAST_END) begin
                        state_r <= MST_CHOP_SLOW;
                        fast_r  <= 1'b0;
                    end
                end
                MST_CHOP_SLOW: begin
                    fast_r <= 1'b0;
                    cnt_r  <= cnt_r + 1'b1;
                    if (cnt_r >= TOFF_LAST) begin
                        state_r <= MST_CHOP_DRIVE;
                    end
                end
                default: begin
                    state_r <= MST_CHOP_DRIVE;
                    fast_r  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drive_o <= 1'b0;
        end else begin
            drive_o <= enable_i && (state_r == MST_CHOP_DRIVE) && !trip_i;
        end
    end

    assign fast_decay_o = fast_r;
endmodule // mst_off_timer
`default_nettype wire

//--- design/mst_pkg.sv
// Types shared by the microstep translator
package mst_pkg;
    typedef enum logic [1:0] {
        MST_RES_FULL,
        MST_RES_HALF,
        MST_RES_QUARTER,
        MST_RES_SIXTEENTH
    } mst_res_t;

    typedef enum logic [1:0] {
        MST_CHOP_DRIVE,
        MST_CHOP_FAST,
        MST_CHOP_SLOW
    } mst_chop_t;
endpackage

//--- design/mst_translator.sv
// Step/direction translator with phase table, decay choice and sleep/reset
`timescale 1ns/1ps
`default_nettype none
`include "mst_defines.svh"

module mst_translator
    import mst_pkg::*;
#(
    parameter int RP_MIN_NS = `MST_RP_MIN_NS,
    parameter int RP_MAX_NS = `MST_RP_MAX_NS,
    parameter int SETTLE_NS = `MST_SETTLE_NS,
    parameter int TOFF_NS   = `MST_TOFF_NS,
    parameter int CNT_W     = 16
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  step_i,
    input  wire logic                  dir_i,
    input  wire logic                  resolution_select_lo_i,
    input  wire logic                  resolution_select_hi_i,
    input  wire logic                  sleep_reset_n_i,
    input  wire logic                  enable_n_i,
    input  wire logic                  phase1_trip_i,
    input  wire logic                  phase2_trip_i,
    output var  logic [`MST_LVL_W-1:0] phase1_level_o,
    output var  logic [`MST_LVL_W-1:0] phase2_level_o,
    output var  logic                  phase1_positive_o,
    output var  logic                  phase2_positive_o,
    output var  logic                  phase1_mixed_o,
    output var  logic                  phase2_mixed_o,
    output var  logic                  phase1_drive_o,
    output var  logic                  phase2_drive_o,
    output var  logic                  phase1_fast_decay_o,
    output var  logic                  phase2_fast_decay_o,
    output var  logic [`MST_IDX_W-1:0] position_o,
    output var  logic                  sleep_o,
    output var  logic                  regulator_on_o,
    output var  logic                  regulator_ready_o
);
    // ------------------------------------------------------------
    // Time counts
    // ------------------------------------------------------------
    localparam int RP_MIN_CYC  = (RP_MIN_NS + `MST_CLK_PERIOD_NS - 1) / `MST_CLK_PERIOD_NS;
    localparam int RP_MAX_CYC  = (RP_MAX_NS / `MST_CLK_PERIOD_NS < 1) ? 1 : RP_MAX_NS / `MST_CLK_PERIOD_NS;
    localparam int SETTLE_CYC  = (SETTLE_NS + `MST_CLK_PERIOD_NS - 1) / `MST_CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] RP_MIN_C = CNT_W'(RP_MIN_CYC < 1 ? 1 : RP_MIN_CYC);
    localparam logic [CNT_W-1:0] RP_MAX_C = CNT_W'(RP_MAX_CYC);
    localparam logic [CNT_W-1:0] SETTLE_C = CNT_W'(SETTLE_CYC);

    // ------------------------------------------------------------
    // Table helpers
    // ------------------------------------------------------------
    // Level in 64ths of full-scale current over a quarter wave
    function automatic logic [`MST_LVL_W-1:0] quarter_level(input logic [4:0] k);
        case (k)
            5'h00:   quarter_level = 7'h00;
            5'h01:   quarter_level = 7'h06;
            5'h02:   quarter_level = 7'h0c;
            5'h03:   quarter_level = 7'h13;
            5'h04:   quarter_level = 7'h18;
            5'h05:   quarter_level = 7'h1e;
            5'h06:   quarter_level = 7'h24;
            5'h07:   quarter_level = 7'h29;
            5'h08:   quarter_level = 7'h2d;
            5'h09:   quarter_level = 7'h31;
            5'h0a:   quarter_level = 7'h35;
            5'h0b:   quarter_level = 7'h38;
            5'h0c:   quarter_level = 7'h3b;
            5'h0d:   quarter_level = 7'h3d;
            5'h0e:   quarter_level = 7'h3f;
            default: quarter_level = 7'h40;
        endcase
    endfunction

    function automatic logic [`MST_LVL_W-1:0] phase_level(input logic [`MST_IDX_W-1:0] idx);
        logic [4:0] r;
        r = {1'b0, idx[3:0]};
        phase_level = quarter_level(idx[4] ? `MST_QUAD_SPAN - r : r);
    endfunction

    // Sine phase is positive in the first half turn
    function automatic logic phase_positive(input logic [`MST_IDX_W-1:0] idx);
        phase_positive = !idx[5];
    endfunction

    function automatic logic [`MST_IDX_W-1:0] step_size(input mst_res_t res);
        case (res)
            MST_RES_FULL:    step_size = `MST_INC_FULL;
            MST_RES_HALF:    step_size = `MST_INC_HALF;
            MST_RES_QUARTER: step_size = `MST_INC_QUARTER;
            default:         step_size = `MST_INC_SIXTEENTH;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [`MST_SYNC_W-1:0] pin_s1_r;
    logic [`MST_SYNC_W-1:0] pin_s2_r;
    logic [`MST_SYNC_W-1:0] pin_s3_r;
    logic [`MST_SYNC_W-1:0] pin_r;
    logic [`MST_SYNC_W-1:0] pins;

    assign pins = {phase2_trip_i, phase1_trip_i, sleep_reset_n_i, enable_n_i,
                   resolution_select_hi_i, resolution_select_lo_i, dir_i, step_i};

    // Sleep and disable idle high so reset does not fake a sleep pulse
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_r <= `MST_SYNC_RESET;
            pin_s2_r <= `MST_SYNC_RESET;
            pin_s3_r <= `MST_SYNC_RESET;
            pin_r    <= `MST_SYNC_RESET;
        end else begin
            pin_s1_r <= pins;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            for (int i = 0; i < `MST_SYNC_W; i++) begin
                if (pin_s2_r[i] == pin_s3_r[i]) begin
                    pin_r[i] <= pin_s3_r[i];
                end
            end
        end
    end

    logic step_s;
    logic dir_s;
    logic enable_n_s;
    logic sleep_n_s;
    logic step_prev_r;
    logic sleep_n_prev_r;
    mst_res_t res_s;

    assign step_s     = pin_r[0];
    assign dir_s      = pin_r[1];
    assign res_s      = mst_res_t'({pin_r[3], pin_r[2]});
    assign enable_n_s = pin_r[4];
    assign sleep_n_s  = pin_r[5];

    // ------------------------------------------------------------
    // Sleep / reset pulse handling
    // ------------------------------------------------------------
    logic [CNT_W-1:0] low_cnt_r;
    logic [CNT_W-1:0] settle_cnt_r;
    logic             go_home;
    logic             step_edge;

    // Release after a window-length pulse or after sleep returns home
    assign go_home = sleep_n_s && !sleep_n_prev_r &&
                     (sleep_o || low_cnt_r >= RP_MIN_C);
    // Steps are taken whatever the enable; only sleep or a low sleep/reset pin blocks them
    assign step_edge = step_s && !step_prev_r && !sleep_o && sleep_n_s;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_prev_r    <= 1'b0;
            sleep_n_prev_r <= 1'b1;
        end else begin
            step_prev_r    <= step_s;
            sleep_n_prev_r <= sleep_n_s;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_r <= '0;
            sleep_o   <= 1'b0;
        end else if (!sleep_n_s) begin
            if (low_cnt_r < RP_MAX_C) begin
                low_cnt_r <= low_cnt_r + 1'b1;
            end else begin
                sleep_o <= 1'b1;
            end
        end else begin
            low_cnt_r <= '0;
            sleep_o   <= 1'b0;
        end
    end

    // Regulator settling flag; stepping early is the controller's fault
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            regulator_on_o    <= 1'b1;
            settle_cnt_r      <= '0;
            regulator_ready_o <= 1'b1;
        end else begin
            regulator_on_o <= !(sleep_o || (!sleep_n_s && low_cnt_r >= RP_MAX_C));
            if (sleep_o) begin
                settle_cnt_r      <= '0;
                regulator_ready_o <= 1'b0;
            end else if (settle_cnt_r < SETTLE_C) begin
                settle_cnt_r <= settle_cnt_r + 1'b1;
            end else begin
                regulator_ready_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Translator
    // ------------------------------------------------------------
    logic [`MST_IDX_W-1:0] idx_nxt;
    logic [`MST_IDX_W-1:0] idx2_nxt;
    logic [`MST_LVL_W-1:0] lvl1_nxt;
    logic [`MST_LVL_W-1:0] lvl2_nxt;

    // Direction and resolution only matter here, at the edge
    assign idx_nxt  = dir_s ? position_o + step_size(res_s)
                            : position_o - step_size(res_s);
    assign idx2_nxt = idx_nxt + `MST_PHASE2_OFFSET;
    assign lvl1_nxt = phase_level(idx_nxt);
    assign lvl2_nxt = phase_level(idx2_nxt);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            position_o        <= `MST_HOME_IDX;
            phase1_level_o    <= phase_level(`MST_HOME_IDX);
            phase2_level_o    <= phase_level(`MST_HOME_IDX + `MST_PHASE2_OFFSET);
            phase1_positive_o <= phase_positive(`MST_HOME_IDX);
            phase2_positive_o <= phase_positive(`MST_HOME_IDX + `MST_PHASE2_OFFSET);
            phase1_mixed_o    <= 1'b1;
            phase2_mixed_o    <= 1'b1;
        end else if (go_home) begin
            position_o        <= `MST_HOME_IDX;
            phase1_level_o    <= phase_level(`MST_HOME_IDX);
            phase2_level_o    <= phase_level(`MST_HOME_IDX + `MST_PHASE2_OFFSET);
            phase1_positive_o <= phase_positive(`MST_HOME_IDX);
            phase2_positive_o <= phase_positive(`MST_HOME_IDX + `MST_PHASE2_OFFSET);
            phase1_mixed_o    <= 1'b1;
            phase2_mixed_o    <= 1'b1;
        end else if (step_edge) begin
            position_o        <= idx_nxt;
            phase1_level_o    <= lvl1_nxt;
            phase2_level_o    <= lvl2_nxt;
            phase1_positive_o <= phase_positive(idx_nxt);
            phase2_positive_o <= phase_positive(idx2_nxt);
            phase1_mixed_o    <= lvl1_nxt < phase1_level_o;
            phase2_mixed_o    <= lvl2_nxt < phase2_level_o;
        end
    end

    // ------------------------------------------------------------
    // Bridge chopping
    // ------------------------------------------------------------
    logic drivers_en_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drivers_en_r <= 1'b0;
        end else begin
            drivers_en_r <= !enable_n_s && sleep_n_s && !sleep_o;
        end
    end

    mst_off_timer #(
        .TOFF_NS (TOFF_NS),
        .CNT_W   (CNT_W)
    ) u_chop1 (
        .sys_clk_i    (sys_clk_i),
        .rst_i        (rst_i),
        .enable_i     (drivers_en_r),
        .mixed_i      (phase1_mixed_o),
        .trip_i       (pin_r[6]),
        .drive_o      (phase1_drive_o),
        .fast_decay_o (phase1_fast_decay_o)
    );

    mst_off_timer #(
        .TOFF_NS (TOFF_NS),
        .CNT_W   (CNT_W)
    ) u_chop2 (
        .sys_clk_i    (sys_clk_i),
        .rst_i        (rst_i),
        .enable_i     (drivers_en_r),
        .mixed_i      (phase2_mixed_o),
        .trip_i       (pin_r[7]),
        .drive_o      (phase2_drive_o),
        .fast_decay_o (phase2_fast_decay_o)
    );
endmodule // mst_translator
`default_nettype wire

//--- testbench/mst_host.sv
// Controller model driving step, direction, resolution and sleep pins
`timescale 1ns/1ps
`default_nettype none
`include "mst_defines.svh"

module mst_host #(
    parameter int SETTLE_NS = `MST_SETTLE_NS
) (
    input  wire logic sys_clk_i,
    output var  logic step_o,
    output var  logic dir_o,
    output var  logic res_lo_o,
    output var  logic res_hi_o,
    output var  logic sleep_reset_n_o
);
    localparam int SETTLE_CYC = SETTLE_NS / `MST_CLK_PERIOD_NS;
    initial begin
        step_o          = 1'b0;
        dir_o           = 1'b1;
        res_lo_o        = 1'b0;
        res_hi_o        = 1'b0;
        sleep_reset_n_o = 1'b1;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic set_mode(input logic [1:0] res, input logic dir);
        res_lo_o <= res[0];
        res_hi_o <= res[1];
        dir_o    <= dir;
    endtask
    // Setup of 4 cycles and long high/low phases clear the pin filter
    task automatic step_once(input logic [1:0] res, input logic dir);
        set_mode(res, dir);
        wait_cyc(4);
        step_o <= 1'b1;
        wait_cyc(8);
        step_o <= 1'b0;
        wait_cyc(8);
    endtask
    task automatic hold_low(input int n);
        sleep_reset_n_o <= 1'b0;
        wait_cyc(n);
    endtask
    task automatic release_pin();
        sleep_reset_n_o <= 1'b1;
        wait_cyc(8);
    endtask
    // Regulator needs its settle time before the next step
    task automatic settle();
        wait_cyc(SETTLE_CYC + 8);
    endtask
endmodule // mst_host
`default_nettype wire

//--- testbench/mst_translator_asserts.sv
// Port-level assertions for the microstep translator
`timescale 1ns/1ps
`default_nettype none
`include "mst_defines.svh"

module mst_translator_chk
    import mst_pkg::*;
#(
    parameter int TOFF_NS = `MST_TOFF_NS
) (
    input wire logic                  sys_clk_i,
    input wire logic                  rst_i,
    input wire logic                  step_i,
    input wire logic                  sleep_reset_n_i,
    input wire logic [`MST_LVL_W-1:0] phase1_level_o,
    input wire logic [`MST_LVL_W-1:0] phase2_level_o,
    input wire logic                  phase1_positive_o,
    input wire logic                  phase2_positive_o,
    input wire logic                  phase1_mixed_o,
    input wire logic                  phase2_mixed_o,
    input wire logic                  phase1_drive_o,
    input wire logic                  phase2_drive_o,
    input wire logic                  phase1_fast_decay_o,
    input wire logic [`MST_IDX_W-1:0] position_o,
    input wire logic                  sleep_o,
    input wire logic                  regulator_on_o
);
    localparam int FAST_CYC = (TOFF_NS / `MST_CLK_PERIOD_NS) * `MST_FAST_PERMILLE / `MST_PERMILLE;
    // ----
    // Helpers
    // ----
    logic       step_q_r;
    logic [3:0] since_rise_r;
    logic [3:0] fast_run_r;
    // Saturates at 15 so a move long after any step can only be a home
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_q_r     <= 1'b0;
            since_rise_r <= 4'hf;
            fast_run_r   <= 4'h0;
        end else begin
            step_q_r     <= step_i;
            since_rise_r <= (step_i && !step_q_r) ? 4'h0 : since_rise_r + {3'h0, since_rise_r != 4'hf};
            fast_run_r   <= phase1_fast_decay_o ? fast_run_r + 4'h1 : 4'h0;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_awake;
        (sleep_reset_n_i && !sleep_o) [*8];
    endsequence
    sequence s_step_taken;
        s_awake ##0 $rose(step_i) ##1 step_i;
    endsequence
    // ----
    // Properties
    // ----
    AST_RESET_HOME: assert property ($fell(rst_i) |-> position_o == `MST_HOME_IDX
        && phase1_level_o == 7'h2d && phase2_level_o == 7'h2d && phase1_positive_o && phase2_positive_o
        && phase1_mixed_o && phase2_mixed_o) else $error("reset state not home");
    AST_STEP_MOVES: assert property (s_step_taken |-> ##[2:8] $changed(position_o))
        else $error("step edge did not move the index");
    AST_STEP_SIZE: assert property ($changed(position_o) && since_rise_r != 4'hf |->
        6'(position_o - $past(position_o)) inside {6'h01, 6'h04, 6'h08, 6'h10, 6'h30, 6'h38, 6'h3c, 6'h3f})
        else $error("index moved by an illegal amount");
    AST_IDLE_HOME_ONLY: assert property ($changed(position_o) && since_rise_r == 4'hf |->
        position_o == `MST_HOME_IDX) else $error("index moved without a step");
    AST_PHASE1_DECAY: assert property ($changed(position_o) && position_o != `MST_HOME_IDX |->
        phase1_mixed_o == (phase1_level_o < $past(phase1_level_o))) else $error("phase1 decay choice wrong");
    AST_PHASE2_DECAY: assert property ($changed(position_o) && position_o != `MST_HOME_IDX |->
        phase2_mixed_o == (phase2_level_o < $past(phase2_level_o))) else $error("phase2 decay choice wrong");
    AST_POLARITY: assert property (phase1_positive_o == !position_o[5] &&
        phase2_positive_o == (position_o[5] == position_o[4])) else $error("polarity does not match index");
    AST_SLEEP_OFF: assert property (sleep_o |-> !phase1_drive_o && !phase2_drive_o && !regulator_on_o)
        else $error("drivers or regulator on in sleep");
    AST_SLEEP_FREEZE: assert property (sleep_o && $past(sleep_o) |-> $stable(position_o))
        else $error("index moved in sleep");
    AST_WAKE_HOME: assert property ($fell(sleep_o) |-> position_o == `MST_HOME_IDX &&
        phase1_mixed_o && phase2_mixed_o) else $error("wake not at home");
    AST_FAST_SPAN: assert property ($fell(phase1_fast_decay_o) |-> fast_run_r == 4'(FAST_CYC))
        else $error("fast decay span wrong");
endmodule // mst_translator_chk

bind mst_translator mst_translator_chk #(.TOFF_NS(TOFF_NS)) mst_translator_chk_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .step_i(step_i), .sleep_reset_n_i(sleep_reset_n_i),
    .phase1_level_o(phase1_level_o), .phase2_level_o(phase2_level_o),
    .phase1_positive_o(phase1_positive_o), .phase2_positive_o(phase2_positive_o),
    .phase1_mixed_o(phase1_mixed_o), .phase2_mixed_o(phase2_mixed_o),
    .phase1_drive_o(phase1_drive_o), .phase2_drive_o(phase2_drive_o),
    .phase1_fast_decay_o(phase1_fast_decay_o), .position_o(position_o),
    .sleep_o(sleep_o), .regulator_on_o(regulator_on_o));
`default_nettype wire

//--- testbench/mst_translator_bench.sv
// Self-checking bench for the microstep translator
`timescale 1ns/1ps
`default_nettype none
`include "mst_defines.svh"

module mst_translator_bench;
    localparam int TOFF_NS  = 400;
    localparam int FAST_CYC = (TOFF_NS / `MST_CLK_PERIOD_NS) * `MST_FAST_PERMILLE / `MST_PERMILLE;
    localparam logic [6:0] QTAB [17] = '{7'h00, 7'h06, 7'h0c, 7'h13, 7'h18, 7'h1e, 7'h24, 7'h29,
        7'h2d, 7'h31, 7'h35, 7'h38, 7'h3b, 7'h3d, 7'h3f, 7'h40, 7'h40};
    localparam logic [5:0] INCS [4] = '{`MST_INC_FULL, `MST_INC_HALF, `MST_INC_QUARTER, `MST_INC_SIXTEENTH};
    localparam logic [1:0] RESS [10] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    localparam logic [9:0] DIRS = 10'h03f;
    logic       sys_clk  = 1'b0;
    logic       rst      = 1'b1;
    logic       enable_n = 1'b1;
    logic       trip1    = 1'b0;
    logic       trip2    = 1'b0;
    logic       step, dir, res_lo, res_hi, sleep_n;
    logic       pos1, pos2, mix1, mix2, drv1, drv2, fast1, fast2, sleep, reg_on, reg_rdy;
    logic [6:0] lvl1, lvl2;
    logic [5:0] posn;
    int         bad_count       = 0;
    int         samples_checked = 0;

    always #20 sys_clk = ~sys_clk;

    mst_translator #(.RP_MIN_NS(400), .RP_MAX_NS(2000), .SETTLE_NS(4000), .TOFF_NS(TOFF_NS)) mst_translator_i (
        .sys_clk_i(sys_clk), .rst_i(rst), .step_i(step), .dir_i(dir), .resolution_select_lo_i(res_lo),
        .resolution_select_hi_i(res_hi), .sleep_reset_n_i(sleep_n), .enable_n_i(enable_n),
        .phase1_trip_i(trip1), .phase2_trip_i(trip2), .phase1_level_o(lvl1), .phase2_level_o(lvl2),
        .phase1_positive_o(pos1), .phase2_positive_o(pos2), .phase1_mixed_o(mix1), .phase2_mixed_o(mix2),
        .phase1_drive_o(drv1), .phase2_drive_o(drv2), .phase1_fast_decay_o(fast1),
        .phase2_fast_decay_o(fast2), .position_o(posn), .sleep_o(sleep), .regulator_on_o(reg_on),
        .regulator_ready_o(reg_rdy));
    mst_host mst_host_i (.sys_clk_i(sys_clk), .step_o(step), .dir_o(dir),
        .res_lo_o(res_lo), .res_hi_o(res_hi), .sleep_reset_n_o(sleep_n));

    // ----
    // Checking helpers
    // ----
    function automatic logic [6:0] lvl_of(input logic [5:0] idx);
        logic [4:0] k;
        k = idx[4:0];
        return QTAB[k > 5'h10 ? 5'h00 - k : k];
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_state(input logic [5:0] p, input logic m1, input logic m2);
        check("position", 8'(posn), 8'(p));
        check("phase1 level", 8'(lvl1), 8'(lvl_of(p)));
        check("phase2 level", 8'(lvl2), 8'(lvl_of(p + 6'h10)));
        check("phase signs", 8'({pos1, pos2}), 8'({!p[5], p[5] == p[4]}));
        check("phase1 mixed", 8'(mix1), 8'(m1));
        check("phase2 mixed", 8'(mix2), 8'(m2));
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #3ms;
        bad_count++;
        report_and_stop();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        logic [5:0] p;
        logic [5:0] np;
        int         n1;
        int         n2;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check_state(`MST_HOME_IDX, 1'b1, 1'b1);
        enable_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        n1 = 0;
        n2 = 0;
        for (int c = 0; c < 46; c++) begin
            trip1 <= (c < 6);
            trip2 <= (c < 6);
            @(posedge sys_clk);
            n1 += int'(fast1 === 1'b1);
            n2 += int'(fast2 === 1'b1);
        end
        check("fast cycles", 8'(n1), 8'(FAST_CYC));
        check("fast cycles 2", 8'(n2), 8'(FAST_CYC));
        p = `MST_HOME_IDX;
        for (int i = 0; i < 10; i++) begin
            enable_n <= i[0];
            // Opposite settings between steps must not move anything
            mst_host_i.set_mode(~RESS[i], ~DIRS[i]);
            repeat (12) @(posedge sys_clk);
            check("idle position", 8'(posn), 8'(p));
            np = DIRS[i] ? p + INCS[RESS[i]] : p - INCS[RESS[i]];
            mst_host_i.step_once(RESS[i], DIRS[i]);
            check_state(np, lvl_of(np) < lvl_of(p), lvl_of(np + 6'h10) < lvl_of(p + 6'h10));
            p = np;
        end
        enable_n <= 1'b0;
        mst_host_i.hold_low(20);
        check("sleep in pulse", 8'(sleep), 8'h00);
        mst_host_i.release_pin();
        check_state(`MST_HOME_IDX, 1'b1, 1'b1);
        mst_host_i.settle();
        mst_host_i.step_once(2'h3, 1'b1);
        mst_host_i.hold_low(80);
        check("sleep", 8'({sleep, reg_on, drv1, drv2}), 8'h08);
        mst_host_i.step_once(2'h0, 1'b1);
        check("position in sleep", 8'(posn), 8'h09);
        mst_host_i.release_pin();
        check_state(`MST_HOME_IDX, 1'b1, 1'b1);
        check("wake flags", 8'({sleep, reg_on, reg_rdy}), 8'h02);
        mst_host_i.settle();
        check("ready", 8'(reg_rdy), 8'h01);
        mst_host_i.step_once(2'h0, 1'b1);
        check_state(6'h18, 1'b0, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check_state(`MST_HOME_IDX, 1'b1, 1'b1);
        report_and_stop();
    end
endmodule // mst_translator_bench
`default_nettype wire
